// ### ipr_field.sv
// One priority field decoder: level and enable from a 3-bit field.
// Assumes the field comes from next-state logic feeding a register on the same clock.
`timescale 1ns/10ps
module ipr_field
   import ipr_pkg::*;
(
   // Field in
   input  wire logic [2:0] field,
   // Decoded priority
   output ipr_prio_t       prio
);

   // ---------------------------------------------------------------
   // Decode
   // ---------------------------------------------------------------
   // The code is the level itself; zero means no request ever
   assign prio.level   = field;
   assign prio.enabled = (field != PRIO_OFF);

endmodule

// ### ipr_pkg.sv
// Constants, types and register map for the interrupt priority register bank.
// Assumes a classic Wishbone master with 32-bit data on the same clock.
//
// How it works
// - External interrupt 1 priority at bits 2:0
// - External interrupt 2 priority at bits 6:4
// - Special event match priority at bits 6:4
// - Serial error priority at bits 6:4
// - PWM gen2 at 14:12, gen1 at 10:8
// - PWM gen4 at 6:4, gen3 at 2:0
// - Comparator 2 at 14:12, rest unimplemented
// - Comparator 4 at 6:4, comparator 3 at 2:0
// - Field value 111 means level 7
// - Values 001 to 111 map to equal level
// - Field value 000 disables the source
// - Unimplemented bits read as zero
// - Reset loads 100, level 4, into fields
package ipr_pkg;

   // ---------------------------------------------------------------
   // Bus geometry
   // ---------------------------------------------------------------
   localparam int ADDR_W = 5;             // Byte address width, eight words
   localparam int REG_W  = 16;            // Implemented register width
   localparam int NREG   = 8;             // Number of registers
   localparam int NSRC   = 11;            // Number of priority fields

   // ---------------------------------------------------------------
   // Register byte offsets
   // ---------------------------------------------------------------
   localparam logic [4:0] OFF_EXT_IRQ1   = 5'h00;
   localparam logic [4:0] OFF_EXT_IRQ2   = 5'h04;
   localparam logic [4:0] OFF_SPECIAL    = 5'h08;
   localparam logic [4:0] OFF_SERIAL_ERR = 5'h0c;
   localparam logic [4:0] OFF_PWM_GEN12  = 5'h10;
   localparam logic [4:0] OFF_PWM_GEN34  = 5'h14;
   localparam logic [4:0] OFF_CMP2       = 5'h18;
   localparam logic [4:0] OFF_CMP34      = 5'h1c;

   // ---------------------------------------------------------------
   // Writable masks per register index, implemented bits only
   // ---------------------------------------------------------------
   localparam logic [15:0] MASK_LO  = 16'h0007;  // Field at 2:0
   localparam logic [15:0] MASK_MID = 16'h0070;  // Field at 6:4
   localparam logic [15:0] MASK_HI  = 16'h7700;  // Fields at 14:12 and 10:8
   localparam logic [15:0] MASK_BT  = 16'h0077;  // Fields at 6:4 and 2:0
   localparam logic [15:0] MASK_TOP = 16'h7000;  // Field at 14:12

   // Every field resets to 100, level 4
   localparam logic [2:0]  PRIO_RST = 3'h4;
   localparam logic [15:0] RST_ALL  = 16'h4444;  // Masked per register
   localparam logic [2:0]  PRIO_OFF = 3'h0;

   // Field low-bit positions
   localparam int POS_LO  = 0;
   localparam int POS_MID = 4;
   localparam int POS_B8  = 8;
   localparam int POS_B12 = 12;

   // Per-source priority and enable, as decoded by ipr_field
   typedef struct packed {
      logic [2:0] level;   // 0..7, 7 highest, 0 when the field is 000
      logic       enabled; // Low when field is 000
   } ipr_prio_t;

   // Bus request bundle
   typedef struct packed {
      logic              cyc;
      logic              stb;
      logic              we;
      logic [3:0]        sel;
      logic [ADDR_W-1:0] adr;
      logic [31:0]       dat;
   } ipr_wb_req_t;

endpackage

// ### ipr_regs.sv
// Interrupt priority register bank with a classic Wishbone slave.
// Assumes one clock, a synchronous active-low reset and a 32-bit bus.
//
// The register offsets and the Wishbone register port were left to the implementer.
`timescale 1ns/10ps
module ipr_regs
   import ipr_pkg::*;
(
   // Clock and reset
   input  wire logic              mclk,
   input  wire logic              rstn,
   // Wishbone slave
   input  wire logic              wb_cyc_i,
   input  wire logic              wb_stb_i,
   input  wire logic              wb_we_i,
   input  wire logic [3:0]        wb_sel_i,
   input  wire logic [ADDR_W-1:0] wb_adr_i,
   input  wire logic [31:0]       wb_dat_i,
   output logic      [31:0]       wb_dat_o,
   output logic                   wb_ack_o,
   output logic                   wb_err_o,
   // Decoded priorities, registered
   output logic      [2:0]        ext_irq1_prio,
   output logic      [2:0]        ext_irq2_prio,
   output logic      [2:0]        special_event_prio,
   output logic      [2:0]        serial_err_prio,
   output logic      [2:0]        pwm_gen1_prio,
   output logic      [2:0]        pwm_gen2_prio,
   output logic      [2:0]        pwm_gen3_prio,
   output logic      [2:0]        pwm_gen4_prio,
   output logic      [2:0]        comparator2_prio,
   output logic      [2:0]        comparator3_prio,
   output logic      [2:0]        comparator4_prio,
   // Per-source enable, low when the field is 000
   output logic      [NSRC-1:0]   src_enable
);

   // ---------------------------------------------------------------
   // Helper functions
   // ---------------------------------------------------------------
   // Writable mask for a register index; unmapped gives zero
   function automatic logic [15:0] reg_mask(input logic [2:0] idx);
      logic [15:0] m;
      m = 16'h0000;
      unique case (idx)
         3'h0: m = MASK_LO;
         3'h1: m = MASK_MID;
         3'h2: m = MASK_MID;
         3'h3: m = MASK_MID;
         3'h4: m = MASK_HI;
         3'h5: m = MASK_BT;
         3'h6: m = MASK_TOP;
         3'h7: m = MASK_BT;
      endcase
      return m;
   endfunction

   // Pick the 3-bit field whose low bit is at pos
   function automatic logic [2:0] fld(input logic [15:0] r, input int pos);
      return r[pos +: 3];
   endfunction

   // ---------------------------------------------------------------
   // Storage and bus decode
   // ---------------------------------------------------------------
   logic [15:0]      regs_reg [NREG];  // Register bank, by index
   logic [15:0]      regs_next [NREG]; // Next value per register
   logic             ack_reg;          // Acknowledge flop
   logic             err_reg;          // Error flop
   logic [31:0]      rdat_reg;         // Read data flop
   ipr_wb_req_t      req;              // Bundled request
   logic             req_new;          // Valid request not yet answered
   logic             addr_ok;          // Word aligned and in range
   logic [2:0]       idx;              // Register index
   logic [15:0]      lane_mask;        // Byte enables as a bit mask
   logic [31:0]      rdat_next;        // Read data selected

   assign req       = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, sel: wb_sel_i,
                        adr: wb_adr_i, dat: wb_dat_i};
   // Answer once per request; ack drops the cycle after
   assign req_new   = req.cyc && req.stb && !ack_reg && !err_reg;
   // Low two bits must be zero; all eight words are mapped
   assign addr_ok   = (req.adr[1:0] == 2'h0);
   assign idx       = req.adr[4:2];
   assign lane_mask = {{8{req.sel[1]}}, {8{req.sel[0]}}};
   // Unimplemented bits read as zero because they are never stored
   assign rdat_next = {16'h0000, regs_reg[idx] & reg_mask(idx)};

   // ---------------------------------------------------------------
   // Next-state per register
   // ---------------------------------------------------------------
   // Only implemented bits in enabled lanes take write data
   genvar g;
   generate
      for (g = 0; g < NREG; g++) begin : g_next
         logic [15:0] wmask;
         assign wmask = reg_mask(3'(g)) & lane_mask;
         assign regs_next[g] = (req_new && addr_ok && req.we && idx == 3'(g))
                               ? ((regs_reg[g] & ~wmask) | (req.dat[15:0] & wmask))
                               : regs_reg[g];
      end
   endgenerate

   // ---------------------------------------------------------------
   // Register bank
   // ---------------------------------------------------------------
   // Every field comes out of reset at level 4
   generate
      for (g = 0; g < NREG; g++) begin : g_reg
         always_ff @(posedge mclk) begin
            if (!rstn) begin
               regs_reg[g] <= RST_ALL & reg_mask(3'(g));
            end else begin
               regs_reg[g] <= regs_next[g];
            end
         end
      end
   endgenerate

   // ---------------------------------------------------------------
   // Bus answer
   // ---------------------------------------------------------------
   // One cycle latency: a request seen at edge N is answered at N+1
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         ack_reg  <= 1'b0;
         err_reg  <= 1'b0;
         rdat_reg <= 32'h0000_0000;
      end else begin
         ack_reg  <= req_new && addr_ok;
         err_reg  <= req_new && !addr_ok;
         // Read data is held zero outside a read answer
         rdat_reg <= (req_new && addr_ok && !req.we) ? rdat_next : 32'h0000_0000;
      end
   end

   assign wb_ack_o = ack_reg;
   assign wb_err_o = err_reg;
   assign wb_dat_o = rdat_reg;

   // ---------------------------------------------------------------
   // Priority outputs
   // ---------------------------------------------------------------
   // Fields are read straight from the register flops
   assign ext_irq1_prio      = fld(regs_reg[0], POS_LO);
   assign ext_irq2_prio      = fld(regs_reg[1], POS_MID);
   assign special_event_prio = fld(regs_reg[2], POS_MID);
   assign serial_err_prio    = fld(regs_reg[3], POS_MID);
   assign pwm_gen2_prio      = fld(regs_reg[4], POS_B12);
   assign pwm_gen1_prio      = fld(regs_reg[4], POS_B8);
   assign pwm_gen4_prio      = fld(regs_reg[5], POS_MID);
   assign pwm_gen3_prio      = fld(regs_reg[5], POS_LO);
   assign comparator2_prio   = fld(regs_reg[6], POS_B12);
   assign comparator4_prio   = fld(regs_reg[7], POS_MID);
   assign comparator3_prio   = fld(regs_reg[7], POS_LO);

   // ---------------------------------------------------------------
   // Source enables
   // ---------------------------------------------------------------
   // Decoded from the next field values and registered, so each enable
   // moves on the same edge as its field and leaves a flop, glitch-free
   logic [2:0]      all_prio [NSRC];  // Next field value per source
   ipr_prio_t       dec [NSRC];       // Decoded next priority per source
   logic [NSRC-1:0] enable_next;      // Next enable per source
   logic [NSRC-1:0] enable_reg;       // Enable flops
   assign all_prio[0]  = fld(regs_next[0], POS_LO);
   assign all_prio[1]  = fld(regs_next[1], POS_MID);
   assign all_prio[2]  = fld(regs_next[2], POS_MID);
   assign all_prio[3]  = fld(regs_next[3], POS_MID);
   assign all_prio[4]  = fld(regs_next[4], POS_B8);
   assign all_prio[5]  = fld(regs_next[4], POS_B12);
   assign all_prio[6]  = fld(regs_next[5], POS_LO);
   assign all_prio[7]  = fld(regs_next[5], POS_MID);
   assign all_prio[8]  = fld(regs_next[6], POS_B12);
   assign all_prio[9]  = fld(regs_next[7], POS_LO);
   assign all_prio[10] = fld(regs_next[7], POS_MID);
   generate
      for (g = 0; g < NSRC; g++) begin : g_dec
         ipr_field u_field (
            .field (all_prio[g]),
            .prio  (dec[g])
         );
         assign enable_next[g] = dec[g].enabled;
      end
   endgenerate

   // Every field leaves reset at a non-zero level, so every source is enabled
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         enable_reg <= {NSRC{PRIO_RST != PRIO_OFF}};
      end else begin
         enable_reg <= enable_next;
      end
   end

   assign src_enable = enable_reg;

endmodule

// ### ipr_regs_asserts.sv
// Checker for the priority register bank, watching only the ports of ipr_regs.
// Assumes the single-cycle classic bus timing of the bank and a low reset.
`timescale 1ns/10ps
module ipr_regs_asserts
   import ipr_pkg::*;
(
   // Clock and reset
   input wire logic              mclk,
   input wire logic              rstn,
   // Bus side
   input wire logic              wb_cyc_i,
   input wire logic              wb_stb_i,
   input wire logic              wb_we_i,
   input wire logic [3:0]        wb_sel_i,
   input wire logic [ADDR_W-1:0] wb_adr_i,
   input wire logic [31:0]       wb_dat_i,
   input wire logic [31:0]       wb_dat_o,
   input wire logic              wb_ack_o,
   input wire logic              wb_err_o,
   // Priority side
   input wire logic [2:0]        ext_irq1_prio,
   input wire logic [2:0]        pwm_gen2_prio,
   input wire logic [2:0]        pwm_gen3_prio,
   input wire logic [2:0]        pwm_gen4_prio,
   input wire logic [2:0]        comparator2_prio,
   input wire logic [2:0]        comparator4_prio,
   input wire logic [NSRC-1:0]   src_enable
);
   // Implemented bits per word; the rest must read as zero
   localparam logic [15:0] MSK [8] = '{16'h0007, 16'h0070, 16'h0070, 16'h0070,
      16'h7700, 16'h0077, 16'h7000, 16'h0077};
   wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o; // Request taken here
   wire wr  = req & wb_we_i & (wb_adr_i[1:0] == 2'h0);      // Aligned write
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);
   a_answer_once: assert property (req |=> (wb_ack_o ^ wb_err_o) ##1 !(wb_ack_o | wb_err_o))
      else $error("bus answer not a single pulse");
   a_misalign_refused: assert property (req && wb_adr_i[1:0] != 2'h0 |=>
      wb_err_o && $stable(ext_irq1_prio)) else $error("misaligned write not refused");
   a_write_ext1: assert property (wr && wb_adr_i[4:2] == 3'h0 && wb_sel_i[0] |=>
      ext_irq1_prio == $past(wb_dat_i[2:0])) else $error("ext1 field not written");
   a_write_gen2: assert property (wr && wb_adr_i[4:2] == 3'h4 && wb_sel_i[1] |=>
      pwm_gen2_prio == $past(wb_dat_i[14:12])) else $error("gen2 field not written");
   a_write_cmp2: assert property (wr && wb_adr_i[4:2] == 3'h6 && wb_sel_i[1] |=>
      comparator2_prio == $past(wb_dat_i[14:12])) else $error("cmp2 field wrong");
   a_write_cmp4: assert property (wr && wb_adr_i[4:2] == 3'h7 && wb_sel_i[0] |=>
      comparator4_prio == $past(wb_dat_i[6:4])) else $error("cmp4 field wrong");
   a_read_gen34: assert property (wb_ack_o && !wb_we_i && wb_adr_i[4:2] == 3'h5 |->
      wb_dat_o[6:0] == {pwm_gen4_prio, 1'b0, pwm_gen3_prio}) else $error("gen34 read");
   a_unimpl_zero: assert property (wb_ack_o && !wb_we_i |->
      (wb_dat_o & ~{16'h0, MSK[wb_adr_i[4:2]]}) == 32'h0) else $error("stray read bits");
   a_disable_flag: assert property (src_enable[0] == (ext_irq1_prio != 3'h0) &&
      src_enable[8] == (comparator2_prio != 3'h0)) else $error("enable decode wrong");
   a_reset_level: assert property (disable iff (1'b0) !rstn |=> ext_irq1_prio == 3'h4 &&
      comparator2_prio == 3'h4 && src_enable == 11'h7ff) else $error("reset level");
   // Main scenarios reached
   c_write: cover property (wr);
   c_refuse: cover property (req && wb_adr_i[1:0] != 2'h0);
   c_read: cover property (wb_ack_o && !wb_we_i);
endmodule
bind ipr_regs ipr_regs_asserts ipr_regs_asserts_i (
   .mclk             (mclk),
   .rstn             (rstn),
   .wb_cyc_i         (wb_cyc_i),
   .wb_stb_i         (wb_stb_i),
   .wb_we_i          (wb_we_i),
   .wb_sel_i         (wb_sel_i),
   .wb_adr_i         (wb_adr_i),
   .wb_dat_i         (wb_dat_i),
   .wb_dat_o         (wb_dat_o),
   .wb_ack_o         (wb_ack_o),
   .wb_err_o         (wb_err_o),
   .ext_irq1_prio    (ext_irq1_prio),
   .pwm_gen2_prio    (pwm_gen2_prio),
   .pwm_gen3_prio    (pwm_gen3_prio),
   .pwm_gen4_prio    (pwm_gen4_prio),
   .comparator2_prio (comparator2_prio),
   .comparator4_prio (comparator4_prio),
   .src_enable       (src_enable)
);

// ### ipr_regs_tb_top.sv
// Self-checking bench for the priority register bank over classic Wishbone.
// Assumes the single-cycle answer and synchronous low reset of the bank.
`timescale 1ns/10ps
module ipr_regs_tb_top
   import ipr_pkg::*;
;
   // -----------------------------------------------------------------
   // Signals
   // -----------------------------------------------------------------
   logic              mclk = 1'b0;
   logic              rstn = 1'b0;
   logic              cyc = 1'b0;
   logic              stb = 1'b0;
   logic              we = 1'b0;
   logic [3:0]        sel = 4'h0;
   logic [ADDR_W-1:0] adr = '0;
   logic [31:0]       dat = 32'h0;
   logic [31:0]       dat_o, q;
   logic              ack, err, e;
   logic [10:0][2:0]  f;   // Fields, index as src_enable
   logic [NSRC-1:0]   en;
   int                fails = 0, tests_run = 0, clk_count = 0;
   logic [15:0] msk [8] = '{16'h0007, 16'h0070, 16'h0070, 16'h0070,
      16'h7700, 16'h0077, 16'h7000, 16'h0077};
   // Stray ones in unimplemented bits prove they are dropped
   logic [15:0] pat [8] = '{16'hfff1, 16'hff2f, 16'hff3f, 16'hff5f,
      16'h6b3f, 16'hff72, 16'h1fff, 16'hff26};
   always #5 mclk = ~mclk;
   ipr_regs ipr_regs_i (.mclk(mclk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_sel_i(sel), .wb_adr_i(adr), .wb_dat_i(dat), .wb_dat_o(dat_o),
      .wb_ack_o(ack), .wb_err_o(err), .ext_irq1_prio(f[0]), .ext_irq2_prio(f[1]),
      .special_event_prio(f[2]), .serial_err_prio(f[3]), .pwm_gen1_prio(f[4]),
      .pwm_gen2_prio(f[5]), .pwm_gen3_prio(f[6]), .pwm_gen4_prio(f[7]),
      .comparator2_prio(f[8]), .comparator3_prio(f[9]), .comparator4_prio(f[10]),
      .src_enable(en));
   // -----------------------------------------------------------------
   // Tasks
   // -----------------------------------------------------------------
   task chk(input logic [35:0] s, input logic [35:0] x);
      tests_run++;
      if (s !== x) begin
         fails++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, x);
      end
   endtask
   // One classic cycle: the request stands until the rising edge that sees ack
   // or err high; data is taken and the request released at that same edge.
   // Only the hang guard below ends a wait that never gets its answer.
   task wb(input logic w, input logic [4:0] a, input logic [31:0] d, input logic [3:0] s);
      @(posedge mclk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      sel <= s;
      do begin
         @(posedge mclk);
      end while (ack !== 1'b1 && err !== 1'b1);
      q = dat_o;
      e = err;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task stop_test;
      $display("Comparisons %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // Hang guard, far above the under two hundred cycles needed
   always @(posedge mclk) begin
      clk_count++;
      if (clk_count == 4000) begin
         fails++;
         stop_test;
      end
   end
   // -----------------------------------------------------------------
   // Sequence
   // -----------------------------------------------------------------
   initial begin
      repeat (8) @(posedge mclk);
      rstn <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         wb(1'b0, 5'(i * 4), 32'h0, 4'hf);
         chk(q, {16'h0, 16'h4444 & msk[i]});
      end
      chk(f, {11{3'h4}});
      chk(en, 11'h7ff);
      for (int i = 0; i < 8; i++) begin
         wb(1'b1, 5'(i * 4), 32'hffffffff, 4'hf);
         wb(1'b0, 5'(i * 4), 32'h0, 4'hf);
         chk(q, {16'h0, msk[i]});
      end
      chk(f, {11{3'h7}});
      for (int i = 0; i < 8; i++) begin
         wb(1'b1, 5'(i * 4), 32'h0, 4'hf);
      end
      chk(en, 11'h000);
      chk(f, 36'h0);
      for (int i = 0; i < 8; i++) begin
         wb(1'b1, 5'(i * 4), {16'hffff, pat[i]}, 4'hf);
         wb(1'b0, 5'(i * 4), 32'h0, 4'hf);
         chk(q, {16'h0, pat[i] & msk[i]});
      end
      chk(f, {3'h2, 3'h6, 3'h1, 3'h7, 3'h2, 3'h6, 3'h3, 3'h5, 3'h3, 3'h2, 3'h1});
      chk({f[1], f[0]}, 6'o21);
      chk(f[2], 3'h3);
      chk({f[3], f[2]}, 6'o53);
      chk({f[5], f[4]}, 6'o63);
      chk({f[10], f[9], f[8]}, 9'o261);
      // Byte lane 0 alone must not reach the fields in bits 15:8
      wb(1'b1, 5'h10, 32'h0, 4'h1);
      chk(f[5], 3'h6);
      wb(1'b1, 5'h10, 32'h0, 4'h2);
      chk({en[5], f[5]}, 4'h0);
      wb(1'b1, 5'h01, 32'h0, 4'hf);
      chk({e, f[0]}, 4'h9);
      // Reset again in mid-run
      rstn <= 1'b0;
      repeat (2) @(posedge mclk);
      rstn <= 1'b1;
      @(negedge mclk);
      chk(f, {11{3'h4}});
      chk(en, 11'h7ff);
      // The bus must answer again straight after the release
      wb(1'b0, 5'h1c, 32'h0, 4'hf);
      chk({e, q}, {1'b0, 32'h0000_0044});
      stop_test;
   end
endmodule
